// file: bit_sync.v
// two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/10ps
module bit_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire ref_clk,
  input wire arst_n,
  input wire din,
  output reg dout
);
  reg stage1;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// file: serial_control_port.v
// serial register-access port: instruction decode, byte transfer, register file
`timescale 1ns/10ps
`include "serial_control_port_regs.vh"
module serial_control_port (
  input wire ref_clk,
  input wire arst_n,
  input wire sclk,
  input wire select_n,
  input wire sdioIn,
  output reg sdioOut,
  output wire sdioOe_n,
  output reg data_out_pin,
  output wire dataOutOe_n,
  input wire update_strobe_pin,
  output reg split_data_enable,
  output reg lsbFirst,
  output reg [8*`LIVE_BYTES-1:0] liveRegs,
  output wire [8*`BUF_BYTES-1:0] tuneActive
);
  localparam ST_INSTR = 3'b001;
  localparam ST_DATA = 3'b010;
  localparam ST_DONE = 3'b100;

  wire sclkSync;
  wire selSync;
  wire sdiSync;
  wire updSync;
  reg sclkPrev;
  reg selPrev;
  reg updPrev;

  // all sampling runs on ref_clk, the system clock of the port
  bit_sync #(.RESET_VAL(1'b0)) syncSclk (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .din(sclk),
    .dout(sclkSync)
  );
  bit_sync #(.RESET_VAL(1'b1)) syncSel (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .din(select_n),
    .dout(selSync)
  );
  bit_sync #(.RESET_VAL(1'b0)) syncSdi (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .din(sdioIn),
    .dout(sdiSync)
  );
  bit_sync #(.RESET_VAL(1'b0)) syncUpd (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .din(update_strobe_pin),
    .dout(updSync)
  );

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkPrev <= 1'b0;
      selPrev <= 1'b1;
      updPrev <= 1'b0;
    end else begin
      sclkPrev <= sclkSync;
      selPrev <= selSync;
      updPrev <= updSync;
    end
  end

  // each serial clock phase must last at least one system clock or an edge is missed
  // serial clock edges only count inside a frame
  wire sclkRise = sclkSync & ~sclkPrev & ~selSync;
  wire sclkFall = ~sclkSync & sclkPrev & ~selSync;
  wire selRise = selSync & ~selPrev;
  wire updToggle = updSync ^ updPrev;

  reg [2:0] state;
  reg [2:0] bitCnt;
  reg instrHi;
  reg [15:0] instrSh;
  reg [7:0] dataSh;
  reg [7:0] outSh;
  reg isRead;
  reg stream;
  reg [1:0] bytesLeft;
  reg [`ADDR_W-1:0] addr;
  reg wrStb;
  reg [`ADDR_W-1:0] wrAddr;
  reg [7:0] wrData;
  reg readBuffered;
  reg lsbShadow;
  reg updateReq;

  // msb-first shifts left, lsb-first shifts right
  wire [15:0] next_instr = lsbFirst ? {sdiSync, instrSh[15:1]} : {instrSh[14:0], sdiSync};
  wire [7:0] next_data = lsbFirst ? {sdiSync, dataSh[7:1]} : {dataSh[6:0], sdiSync};
  wire [`ADDR_W-1:0] next_addr = lsbFirst ? addr + 13'h0001 : addr - 13'h0001;

  // read path
  wire [7:0] bankRd;
  wire [`ADDR_W-1:0] bufOff = addr - `ADDR_BUF_BASE;
  wire [`ADDR_W-1:0] liveOff = addr - `ADDR_LIVE_BASE;
  wire inBuf = (addr >= `ADDR_BUF_BASE) && (addr < `ADDR_BUF_BASE + `BUF_BYTES);
  wire inLive = (addr >= `ADDR_LIVE_BASE) && (addr < `ADDR_LIVE_BASE + `LIVE_BYTES);
  reg [7:0] rdByte;
  // identity bytes are fixed and ignore writes
  wire [15:0] partId = `PART_ID;

  always @* begin
    rdByte = 8'h00;
    if (addr <= `ADDR_MAP_TOP) begin
      if (addr == `ADDR_CONFIG) begin
        rdByte[`CFG_SPLIT_BIT] = split_data_enable;
        rdByte[`CFG_LSB_FIRST_BIT] = readBuffered ? lsbShadow : lsbFirst;
      end else if (addr == `ADDR_ID_LO) begin
        rdByte = partId[7:0];
      end else if (addr == `ADDR_ID_HI) begin
        rdByte = partId[15:8];
      end else if (addr == `ADDR_READ_OPT) begin
        rdByte[`READ_OPT_BUF_BIT] = readBuffered;
      end else if (inLive) begin
        rdByte = liveRegs[8*liveOff[1:0] +: 8];
      end else if (inBuf) begin
        rdByte = bankRd;
      end
    end
  end

  // serial protocol engine
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_INSTR;
      bitCnt <= 3'h0;
      instrHi <= 1'b0;
      instrSh <= 16'h0000;
      dataSh <= 8'h00;
      isRead <= 1'b0;
      stream <= 1'b0;
      bytesLeft <= 2'h0;
      addr <= 13'h0000;
      wrStb <= 1'b0;
      wrAddr <= 13'h0000;
      wrData <= 8'h00;
    end else begin
      wrStb <= 1'b0;
      if (selRise) begin
        if (bitCnt != 3'h0) begin
          // off-boundary rise: drop partial byte, await new instruction
          state <= ST_INSTR;
          instrHi <= 1'b0;
          bitCnt <= 3'h0;
        end else if (state == ST_DONE || (state == ST_DATA && stream)) begin
          state <= ST_INSTR;
          instrHi <= 1'b0;
        end
        // otherwise on a boundary in the instruction phase or a short transfer's data phase: stall and hold position
      end else if (sclkRise) begin
        bitCnt <= bitCnt + 3'h1;
        case (state)
          ST_INSTR: begin
            instrSh <= next_instr;
            if (bitCnt == 3'h7) begin
              instrHi <= 1'b1;
              if (instrHi) begin
                // flag, length code, start address
                state <= ST_DATA;
                isRead <= next_instr[15];
                stream <= (next_instr[14:13] == `LEN_STREAM);
                bytesLeft <= next_instr[14:13];
                addr <= next_instr[12:0];
              end
            end
          end
          ST_DATA: begin
            dataSh <= next_data;
            if (bitCnt == 3'h7) begin
              if (!isRead) begin
                wrStb <= 1'b1; // full byte only
                wrAddr <= addr;
                wrData <= next_data;
              end
              addr <= next_addr;
              if (!stream) begin
                if (bytesLeft == 2'h0) begin
                  state <= ST_DONE;
                end else begin
                  bytesLeft <= bytesLeft - 2'h1;
                end
              end
            end
          end
          ST_DONE: begin
            bitCnt <= 3'h0;
          end
          default: begin
            state <= ST_INSTR;
          end
        endcase
      end
    end
  end

  // read shifter: launch on the falling serial clock, bit stands until the next fall
  wire launchRead = sclkFall & (state == ST_DATA) & isRead;
  wire [7:0] launchSrc = (bitCnt == 3'h0) ? rdByte : outSh;
  wire launchBit = lsbFirst ? launchSrc[0] : launchSrc[7];
  wire [7:0] next_out = lsbFirst ? {1'b0, launchSrc[7:1]} : {launchSrc[6:0], 1'b0};

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      outSh <= 8'h00;
      sdioOut <= 1'b0;
      data_out_pin <= 1'b0;
    end else if (launchRead) begin
      // a fresh byte loads at each boundary
      outSh <= next_out;
      sdioOut <= launchBit;
      data_out_pin <= launchBit;
    end
  end

  // pins released while deselected; read data steered by split mode
  // raw select_n releases the pins at once, ahead of the synchroniser delay
  wire driving = ~selSync & ~select_n & (state == ST_DATA) & isRead;
  assign sdioOe_n = ~(driving & ~split_data_enable);
  assign dataOutOe_n = ~(driving & split_data_enable);

  // register writes
  wire wrInMap = wrStb && (wrAddr <= `ADDR_MAP_TOP);
  wire [`ADDR_W-1:0] wrBufOff = wrAddr - `ADDR_BUF_BASE;
  wire [`ADDR_W-1:0] wrLiveOff = wrAddr - `ADDR_LIVE_BASE;
  wire wrBuf = wrInMap && (wrAddr >= `ADDR_BUF_BASE) && (wrAddr < `ADDR_BUF_BASE + `BUF_BYTES);
  wire wrLive = wrInMap && (wrAddr >= `ADDR_LIVE_BASE) && (wrAddr < `ADDR_LIVE_BASE + `LIVE_BYTES);
  wire commit = updToggle | updateReq;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      split_data_enable <= 1'b0;
      lsbShadow <= 1'b0;
      lsbFirst <= 1'b0;
      readBuffered <= 1'b0;
      updateReq <= 1'b0;
      liveRegs <= {`LIVE_BYTES{`BYTE_RESET}};
    end else begin
      updateReq <= 1'b0;
      if (commit) begin
        lsbFirst <= lsbShadow;
      end
      if (wrInMap) begin
        // id bytes and unmapped addresses have no write case
        if (wrAddr == `ADDR_CONFIG) begin
          split_data_enable <= wrData[`CFG_SPLIT_BIT];
          lsbShadow <= wrData[`CFG_LSB_FIRST_BIT];
        end else if (wrAddr == `ADDR_READ_OPT) begin
          readBuffered <= wrData[`READ_OPT_BUF_BIT];
        end else if (wrAddr == `ADDR_UPDATE) begin
          updateReq <= wrData[`UPDATE_BIT]; // self clearing
        end else if (wrLive) begin
          liveRegs[8*wrLiveOff[1:0] +: 8] <= wrData;
        end
      end
    end
  end

  shadow_bank tuneBank (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wrEn(wrBuf),
    .wrIdx(wrBufOff[3:0]),
    .wrData(wrData),
    .commit(commit),
    .rdIdx(bufOff[3:0]),
    .rdShadow(readBuffered),
    .rdData(bankRd),
    .activeFlat(tuneActive)
  );
endmodule

// file: serial_control_port_regs.vh
// register offsets, field positions, reset values and identity for the serial control port
`ifndef SERIAL_CONTROL_PORT_REGS_VH
`define SERIAL_CONTROL_PORT_REGS_VH

`define ADDR_W 13
`define ADDR_CONFIG 13'h0000
`define ADDR_ID_LO 13'h0002
`define ADDR_ID_HI 13'h0003
`define ADDR_READ_OPT 13'h0004
`define ADDR_UPDATE 13'h0005
`define ADDR_LIVE_BASE 13'h0010
`define ADDR_BUF_BASE 13'h01A0
`define ADDR_MAP_TOP 13'h0509

`define CFG_SPLIT_BIT 0
`define CFG_LSB_FIRST_BIT 6
`define READ_OPT_BUF_BIT 0
`define UPDATE_BIT 0

`define LIVE_BYTES 4
`define BUF_BYTES 16

// identity value is arbitrary
`define PART_ID 16'h5AC3

`define CONFIG_RESET 8'h00
`define BYTE_RESET 8'h00

`define LEN_STREAM 2'h3

`endif

// file: serial_control_port_sva.sv
// pin-level checker for the serial control port
`timescale 1ns/10ps
`include "serial_control_port_regs.vh"
module serial_control_port_sva (
  input wire ref_clk,
  input wire arst_n,
  input wire sclk,
  input wire select_n,
  input wire update_strobe_pin,
  input wire sdioOut,
  input wire sdioOe_n,
  input wire data_out_pin,
  input wire dataOutOe_n,
  input wire split_data_enable,
  input wire lsbFirst,
  input wire [8*`LIVE_BYTES-1:0] liveRegs,
  input wire [8*`BUF_BYTES-1:0] tuneActive
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_idle_off; select_n |-> sdioOe_n && dataOutOe_n; endproperty
  a_idle_off: assert property (p_idle_off) else $error("data pin driven while deselected");
  property p_split_in; split_data_enable && $past(split_data_enable) |-> sdioOe_n; endproperty
  a_split_in: assert property (p_split_in) else $error("shared pin driven in split mode");
  property p_bidir_sdo; !split_data_enable && !$past(split_data_enable) |-> dataOutOe_n; endproperty
  a_bidir_sdo: assert property (p_bidir_sdo) else $error("separate output driven in shared mode");
  property p_one_pin; !dataOutOe_n |-> sdioOe_n; endproperty
  a_one_pin: assert property (p_one_pin) else $error("both data pins driven");
  property p_same_bit; data_out_pin == sdioOut; endproperty
  a_same_bit: assert property (p_same_bit) else $error("data pins carry different bits");
  property p_launch; sclk && $past(sclk) |-> $stable(sdioOut); endproperty
  a_launch: assert property (p_launch) else $error("read bit moved while serial clock high");
  property p_live_quiet; select_n [*8] |=> $stable(liveRegs); endproperty
  a_live_quiet: assert property (p_live_quiet) else $error("live bytes moved while idle");
  property p_active_quiet;
    (select_n && $stable(update_strobe_pin)) [*8] |=> $stable(tuneActive) && $stable(lsbFirst);
  endproperty
  a_active_quiet: assert property (p_active_quiet) else $error("active bytes moved without update");
endmodule
bind serial_control_port serial_control_port_sva chk (.ref_clk(ref_clk), .arst_n(arst_n), .sclk(sclk),
  .select_n(select_n), .update_strobe_pin(update_strobe_pin), .sdioOut(sdioOut), .sdioOe_n(sdioOe_n),
  .data_out_pin(data_out_pin), .dataOutOe_n(dataOutOe_n), .split_data_enable(split_data_enable),
  .lsbFirst(lsbFirst), .liveRegs(liveRegs), .tuneActive(tuneActive));

// file: serial_master_model.sv
// serial master model driving the frame pins
`timescale 1ns/10ps
module serial_master_model (
  input wire ref_clk,
  input wire miso,
  output logic sclk,
  output logic select_n,
  output logic mosi,
  output logic drv
);
  logic lsb = 1'b0;
  logic [7:0] rd [0:7];
  logic [7:0] wr [0:7];
  initial begin
    sclk = 1'b0;
    select_n = 1'b1;
    mosi = 1'b0;
    drv = 1'b0;
  end
  task automatic sel(input logic v);
    @(negedge ref_clk);
    sclk = 1'b0;
    drv = 1'b0;
    select_n = v;
    repeat (8) @(negedge ref_clk);
  endtask
  // nb bits, answer taken at each rising serial clock
  task automatic shift(input logic [7:0] w, input logic rdPhase, input integer nb, output logic [7:0] r);
    integer i;
    r = 8'h00;
    for (i = 0; i < nb; i++) begin
      @(negedge ref_clk);
      sclk = 1'b0;
      mosi = lsb ? w[i] : w[7-i];
      drv = !rdPhase;
      repeat (4) @(negedge ref_clk);
      sclk = 1'b1;
      @(posedge ref_clk);
      r = lsb ? {miso, r[7:1]} : {r[6:0], miso};
      repeat (3) @(negedge ref_clk);
    end
  endtask
  // instruction plus n bytes, stalling after byte index stall
  task automatic frame(input logic rdOp, input logic [1:0] len, input logic [12:0] a, input integer n,
      input integer stall);
    logic [15:0] ins;
    logic [7:0] dummy;
    integer k;
    ins = {rdOp, len, a};
    sel(1'b0);
    for (k = 0; k < n + 2; k++) begin
      if (k < 2) shift(lsb ? ins[8*k +: 8] : ins[8*(1-k) +: 8], 1'b0, 8, dummy);
      else shift(wr[k-2], rdOp, 8, rd[k-2]);
      if (k == stall) begin
        sel(1'b1);
        sel(1'b0);
      end
    end
    sel(1'b1);
  endtask
endmodule

// file: shadow_bank.v
// buffered byte bank: shadow copy written serially, active copy loaded on update
`timescale 1ns/10ps
`include "serial_control_port_regs.vh"
module shadow_bank (
  input wire ref_clk,
  input wire arst_n,
  input wire wrEn,
  input wire [3:0] wrIdx,
  input wire [7:0] wrData,
  input wire commit,
  input wire [3:0] rdIdx,
  input wire rdShadow,
  output wire [7:0] rdData,
  output reg [8*`BUF_BYTES-1:0] activeFlat
);
  reg [7:0] shadow [0:`BUF_BYTES-1];
  integer i;
  integer j;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < `BUF_BYTES; i = i + 1) begin
        shadow[i] <= `BYTE_RESET;
      end
    end else if (wrEn) begin
      shadow[wrIdx] <= wrData;
    end
  end

  // all pending bytes move to the active copy together
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      activeFlat <= {`BUF_BYTES{`BYTE_RESET}};
    end else if (commit) begin
      for (j = 0; j < `BUF_BYTES; j = j + 1) begin
        activeFlat[8*j +: 8] <= shadow[j];
      end
    end
  end

  assign rdData = rdShadow ? shadow[rdIdx] : activeFlat[8*rdIdx +: 8];
endmodule

// file: testbench.sv
// self-checking bench for the serial control port
`timescale 1ns/10ps
`include "serial_control_port_regs.vh"
module testbench;
  logic ref_clk;
  logic arst_n;
  logic updPin;
  logic junk;
  logic splitMode;
  logic [31:0] lfsr = 32'h2481_f00c;
  integer n_mismatch = 0;
  integer checks_done = 0;
  wire sclk, selN, mosi, drv, sdioOut, sdioOe_n, sdoPin, sdoOe_n, split, lsbF;
  wire [8*`LIVE_BYTES-1:0] live;
  wire [8*`BUF_BYTES-1:0] act;
  // released lines show a changing pattern
  wire sdio;
  wire sdoLine;
  wire misoLine;
  assign sdio = !sdioOe_n ? sdioOut : (drv ? mosi : junk);
  assign sdoLine = !sdoOe_n ? sdoPin : junk;
  assign misoLine = splitMode ? sdoLine : sdio;
  serial_master_model m (.ref_clk(ref_clk), .miso(misoLine), .sclk(sclk), .select_n(selN),
    .mosi(mosi), .drv(drv));
  serial_control_port dut (.ref_clk(ref_clk), .arst_n(arst_n), .sclk(sclk), .select_n(selN), .sdioIn(sdio),
    .sdioOut(sdioOut), .sdioOe_n(sdioOe_n), .data_out_pin(sdoPin), .dataOutOe_n(sdoOe_n),
    .update_strobe_pin(updPin), .split_data_enable(split), .lsbFirst(lsbF), .liveRegs(live), .tuneActive(act));
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) junk <= ~junk;
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [159:0] got, input logic [159:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic fill(input integer n);
    integer k;
    for (k = 0; k < n; k++) begin
      m.wr[k] = lfsr[7:0];
      lfsr = step(lfsr);
    end
  endtask
  task automatic put(input logic [12:0] a, input logic [7:0] v);
    m.wr[0] = v;
    m.frame(1'b0, 2'h0, a, 1, -1);
  endtask
  initial begin
    #400_000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    logic [23:0] eLive;
    logic [31:0] e;
    logic [7:0] d;
    ref_clk = 1'b0;
    arst_n = 1'b0;
    updPin = 1'b0;
    junk = 1'b0;
    splitMode = 1'b0;
    repeat (6) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    check({sdioOe_n, sdoOe_n, split, lsbF}, 4'hC);
    check({live, act}, 0);
    fill(3);
    eLive = {m.wr[0], m.wr[1], m.wr[2]};
    m.frame(1'b0, 2'h2, 13'h0012, 3, 2);
    check(live[23:0], eLive);
    m.frame(1'b1, 2'h2, 13'h0012, 3, 0);
    check({m.rd[0], m.rd[1], m.rd[2]}, eLive);
    fill(2);
    m.frame(1'b0, 2'h1, 13'h0003, 2, -1);
    m.frame(1'b1, 2'h1, 13'h0003, 2, -1);
    check({m.rd[0], m.rd[1]}, `PART_ID);
    fill(4);
    e = {m.wr[0], m.wr[1], m.wr[2], m.wr[3]};
    m.frame(1'b0, 2'h3, 13'h01A3, 4, -1);
    check(act, 0);
    put(13'h0004, 8'h01);
    m.frame(1'b1, 2'h3, 13'h01A3, 4, -1);
    check({m.rd[0], m.rd[1], m.rd[2], m.rd[3]}, e);
    put(13'h0004, 8'h00);
    m.frame(1'b1, 2'h0, 13'h01A3, 1, -1);
    check(m.rd[0], 8'h00);
    updPin = 1'b1;
    repeat (8) @(negedge ref_clk);
    check(act[31:0], e);
    fill(1);
    d = m.wr[0];
    m.frame(1'b0, 2'h0, 13'h01A0, 1, -1);
    check(act[7:0], e[7:0]);
    put(13'h0005, 8'h01);
    check(act[7:0], d);
    m.sel(1'b0);
    m.shift(8'h40, 1'b0, 8, d);
    m.shift(8'h10, 1'b0, 8, d);
    m.shift(~eLive[7:0], 1'b0, 5, d);
    m.sel(1'b1);
    check(live[23:0], eLive);
    m.sel(1'b0);
    m.shift(8'h40, 1'b0, 8, d);
    m.sel(1'b1);
    m.sel(1'b0);
    m.shift(8'h10, 1'b0, 3, d);
    m.sel(1'b1);
    fill(1);
    d = m.wr[0];
    m.frame(1'b0, 2'h0, 13'h0010, 1, -1);
    check(live[7:0], d);
    eLive[7:0] = d;
    put(13'h0000, 8'h01);
    splitMode = 1'b1;
    check(split, 1'b1);
    m.frame(1'b1, 2'h2, 13'h0012, 3, -1);
    check({m.rd[0], m.rd[1], m.rd[2]}, eLive);
    put(13'h0000, 8'h40);
    splitMode = 1'b0;
    updPin = 1'b0;
    repeat (8) @(negedge ref_clk);
    check({split, lsbF}, 2'h1);
    m.lsb = 1'b1;
    fill(2);
    m.frame(1'b0, 2'h1, 13'h0011, 2, -1);
    check(live[23:8], {m.wr[1], m.wr[0]});
    wrap_up;
  end
endmodule
